/* File: hw/cif_pkg.sv */
package cif_pkg;

  // ****************************************************
  // Bus geometry and responses
  // ****************************************************
  localparam int AXI_AW = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [AXI_AW-1:0] OFF_INT_CAPT = 8'h00;
  localparam logic [AXI_AW-1:0] OFF_ENABLE = 8'h04;
  localparam logic [AXI_AW-1:0] OFF_MODE = 8'h08;
  localparam logic [AXI_AW-1:0] OFF_COMMAND = 8'h0C;
  localparam logic [AXI_AW-1:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [AXI_AW-1:0] OFF_IRQ_MASK = 8'h14;

  // ****************************************************
  // Flag field positions
  // ****************************************************
  localparam int FLAG_W = 9;
  localparam int BIT_ID_READY = 8;
  localparam int BIT_BUS_ERROR = 7;
  localparam int BIT_ARB_LOST = 6;
  localparam int BIT_ERR_PASSIVE = 5;
  localparam int BIT_RESERVED = 4;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_ERR_WARNING = 2;
  localparam int BIT_TX_DONE_1 = 1;
  localparam int BIT_RX_PENDING = 0;

  // Flags cleared by a read: all but rx pending and reserved
  localparam logic [FLAG_W-1:0] RD_CLR_MASK = 9'h1EE;
  // Flags forced low in soft reset: all but bus error, warning
  localparam logic [FLAG_W-1:0] SOFT_CLR_MASK = 9'h17B;
  // Bits that may ever be set in the flag word
  localparam logic [FLAG_W-1:0] FLAG_VALID_MASK = 9'h1EF;

  // ****************************************************
  // Command and mode bits, reset values
  // ****************************************************
  localparam int CMD_RELEASE_BIT = 0;
  localparam int MODE_SOFT_BIT = 0;
  localparam logic [FLAG_W-1:0] ENABLE_RST = 9'h000;
  localparam logic [FLAG_W-1:0] IRQ_MASK_RST = 9'h000;
  localparam logic SOFT_MODE_RST = 1'b0;

  // ****************************************************
  // Error counter limit for error-passive state
  // ****************************************************
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] EP_LIMIT = 8'h7F;

  // Detector inputs order
  localparam int DET_W = 4;
  localparam int DET_EP = 0;
  localparam int DET_ES = 1;
  localparam int DET_BS = 2;
  localparam int DET_TX1 = 3;

endpackage

/* File: hw/cif_change_det.sv */
`timescale 1ns/1ns
module cif_change_det #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched levels
  input wire logic [W-1:0] level,
  // Edge outputs
  output logic [W-1:0] rise,
  output logic [W-1:0] change
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic primed;
  } cif_det_state_t;

  cif_det_state_t st_ff;
  cif_det_state_t nxt_st;

  // Edges gated until the first sample, so reset levels never fire
  assign rise = st_ff.primed ? (level & ~st_ff.prev) : '0;
  assign change = st_ff.primed ? (level ^ st_ff.prev) : '0;

  // Track previous level
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = level;
    nxt_st.primed = 1'b1;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

/* File: hw/cif_irq_ctl.sv */
`timescale 1ns/1ns
module cif_irq_ctl
  import cif_pkg::*;
#(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Event pulses
  input wire logic [W-1:0] set,
  // Software access
  input wire logic clr_we,
  input wire logic [W-1:0] clr_bits,
  input wire logic mask_we,
  input wire logic [W-1:0] mask_bits,
  // State and interrupt line
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic irq;
  } cif_irq_state_t;

  cif_irq_state_t st_ff;
  cif_irq_state_t nxt_st;

  assign status = st_ff.status;
  assign mask = st_ff.mask;
  assign irq = st_ff.irq;

  // Sticky status; a new event beats a clear in the same cycle
  always_comb begin
    nxt_st = st_ff;
    if (clr_we) begin
      nxt_st.status = st_ff.status & ~clr_bits;
    end
    nxt_st.status = nxt_st.status | set;
    if (mask_we) begin
      nxt_st.mask = mask_bits;
    end
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.mask <= W'(IRQ_MASK_RST);
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

/* File: hw/cif_flag_logic.sv */
// Functional notes
// - Set id-ready flag bit 8 on identifier in filter bypass, if enabled.
// - Set bus-error flag bit 7 on a detected bus error, if enabled.
// - Set arbitration-lost flag bit 6 on lost arbitration, if enabled.
// - Set error-passive flag bit 5 entering or leaving passive, if enabled.
// - Bit 4 of the interrupt and capture word always reads zero.
// - Set overrun flag bit 3 on receive buffer overrun, if enabled.
// - Set error-warning flag bit 2 on error or bus status change, if enabled.
// - Set tx-done flag 1 on buffer 1 rising to released, if enabled.
// - Rx-pending flag bit 0 set while buffer status is one and enabled.
// - Reading the interrupt word leaves rx-pending flag unchanged.
// - Release command clears rx-pending; it returns if messages remain.
// - Reading the interrupt word clears all flags except rx-pending.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module cif_flag_logic
  import cif_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cif_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [cif_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Protocol core events and levels
  input wire logic id_rx_evt,
  input wire logic filter_bypass,
  input wire logic bus_err_evt,
  input wire logic arb_lost_evt,
  input wire logic [cif_pkg::CNT_W-1:0] tx_err_cnt,
  input wire logic [cif_pkg::CNT_W-1:0] rx_err_cnt,
  input wire logic overrun_evt,
  input wire logic err_status,
  input wire logic bus_status,
  input wire logic tx_buf1_status,
  input wire logic rx_buf_status,
  // Commands to the protocol core
  output logic rx_buf_release,
  output logic soft_reset_mode,
  // Interrupt line
  output logic irq
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic awready;
    logic aw_held;
    logic [AXI_AW-1:0] aw_addr;
    logic wready;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] enable;
    logic soft_mode;
    logic release_pulse;
    logic rx_blank;
  } cif_top_state_t;

  cif_top_state_t st_ff;
  cif_top_state_t nxt_st;

  // ****************************************************
  // Helpers
  // ****************************************************

  // Aligned word address of a byte address
  function automatic logic [AXI_AW-1:0] word_addr(
    input logic [AXI_AW-1:0] addr
  );
    word_addr = {addr[AXI_AW-1:2], 2'b00};
  endfunction

  // Data bits of a narrow register that the byte lanes allow
  function automatic logic [FLAG_W-1:0] lane_bits(
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [FLAG_W-1:0] m;
    m = {strb[1], {8{strb[0]}}};
    lane_bits = data[FLAG_W-1:0] & m;
  endfunction

  // Merge a write into a narrow register by byte lane
  function automatic logic [FLAG_W-1:0] merge_lanes(
    input logic [FLAG_W-1:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [FLAG_W-1:0] m;
    m = {strb[1], {8{strb[0]}}};
    merge_lanes = (old & ~m) | (data[FLAG_W-1:0] & m);
  endfunction

  // ****************************************************
  // Event detection
  // ****************************************************
  logic err_passive;
  logic [DET_W-1:0] det_level;
  logic [DET_W-1:0] det_rise;
  logic [DET_W-1:0] det_change;

  // Passive once either counter passes the protocol limit
  assign err_passive = (tx_err_cnt > EP_LIMIT) | (rx_err_cnt > EP_LIMIT);

  // Levels whose edges raise flags
  always_comb begin
    det_level = '0;
    det_level[DET_EP] = err_passive;
    det_level[DET_ES] = err_status;
    det_level[DET_BS] = bus_status;
    det_level[DET_TX1] = tx_buf1_status;
  end

  cif_change_det #(
    .W(DET_W)
  ) u_det (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(det_level),
    .rise(det_rise),
    .change(det_change)
  );

  // ****************************************************
  // Bus decode
  // ****************************************************
  logic wr_go;
  logic [AXI_AW-1:0] wr_addr;
  logic rd_go;
  logic [AXI_AW-1:0] rd_addr;
  logic rd_int_capt;
  logic cmd_release;
  logic irq_clr_we;
  logic irq_mask_we;
  logic [FLAG_W-1:0] wr_bits;
  logic [FLAG_W-1:0] irq_status;
  logic [FLAG_W-1:0] irq_mask;
  logic irq_int;

  // Write fires once address and data are both held and no earlier answer waits
  assign wr_go = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;
  assign wr_addr = word_addr(st_ff.aw_addr);
  assign wr_bits = lane_bits(st_ff.w_data, st_ff.w_strb);
  assign rd_go = s_axi_arvalid & st_ff.arready;
  assign rd_addr = word_addr(s_axi_araddr);
  assign rd_int_capt = rd_go & (rd_addr == OFF_INT_CAPT);
  assign cmd_release = wr_go & (wr_addr == OFF_COMMAND)
    & wr_bits[CMD_RELEASE_BIT];
  assign irq_clr_we = wr_go & (wr_addr == OFF_IRQ_STATUS);
  assign irq_mask_we = wr_go & (wr_addr == OFF_IRQ_MASK);

  // ****************************************************
  // Flag set terms
  // ****************************************************
  logic [FLAG_W-1:0] set_evt;

  // Each event is qualified by its own enable
  always_comb begin
    set_evt = '0;
    set_evt[BIT_ID_READY] = id_rx_evt & filter_bypass;
    set_evt[BIT_BUS_ERROR] = bus_err_evt;
    set_evt[BIT_ARB_LOST] = arb_lost_evt;
    set_evt[BIT_ERR_PASSIVE] = det_change[DET_EP];
    set_evt[BIT_OVERRUN] = overrun_evt;
    set_evt[BIT_ERR_WARNING] = det_change[DET_ES]
      | det_change[DET_BS];
    set_evt[BIT_TX_DONE_1] = det_rise[DET_TX1];
    set_evt = set_evt & st_ff.enable;
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.release_pulse = cmd_release;

    // Write address channel
    if (s_axi_awvalid & st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    // Write data channel, taken in either order
    if (s_axi_wvalid & st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end

    // Perform a held write and answer it
    if (wr_go) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      case (wr_addr)
        OFF_ENABLE: begin
          nxt_st.enable = merge_lanes(st_ff.enable, st_ff.w_data,
            st_ff.w_strb) & FLAG_VALID_MASK;
        end
        OFF_MODE: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.soft_mode = st_ff.w_data[MODE_SOFT_BIT];
          end
        end
        OFF_COMMAND, OFF_IRQ_STATUS, OFF_IRQ_MASK: begin
          nxt_st.bresp = RESP_OKAY;
        end
        // Flag word is read-only; writes to it are refused
        default: begin
          nxt_st.bresp = RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready & st_ff.bvalid) begin
      nxt_st.bvalid = 1'b0;
    end
    // No new beat while one is held; one write at a time
    nxt_st.awready = ~nxt_st.aw_held;
    nxt_st.wready = ~nxt_st.w_held;

    // Read channel: answer one cycle after the address is taken
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.arready = 1'b0;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = '0;
      case (rd_addr)
        OFF_INT_CAPT: begin
          // Reserved bit 4 is never set, so it reads zero
          nxt_st.rdata[FLAG_W-1:0] = st_ff.flags
            & FLAG_VALID_MASK;
        end
        OFF_ENABLE: begin
          nxt_st.rdata[FLAG_W-1:0] = st_ff.enable;
        end
        OFF_MODE: begin
          nxt_st.rdata[MODE_SOFT_BIT] = st_ff.soft_mode;
        end
        OFF_COMMAND: begin
          nxt_st.rdata = '0;
        end
        OFF_IRQ_STATUS: begin
          nxt_st.rdata[FLAG_W-1:0] = irq_status;
        end
        OFF_IRQ_MASK: begin
          nxt_st.rdata[FLAG_W-1:0] = irq_mask;
        end
        default: begin
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready & st_ff.rvalid) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end else if (~st_ff.rvalid) begin
      nxt_st.arready = 1'b1;
    end

    // Event flags: a read clears them, a new event in the
    // same cycle survives the clear
    if (rd_int_capt) begin
      nxt_st.flags = st_ff.flags & ~RD_CLR_MASK;
    end
    nxt_st.flags = nxt_st.flags | set_evt;

    // Rx pending follows the buffer level, never cleared by a
    // read. The release clears it and blanks one more cycle so
    // the core can drop its status before it is sampled again.
    nxt_st.rx_blank = cmd_release;
    if (cmd_release | st_ff.rx_blank) begin
      nxt_st.flags[BIT_RX_PENDING] = 1'b0;
    end else begin
      nxt_st.flags[BIT_RX_PENDING] = rx_buf_status
        & st_ff.enable[BIT_RX_PENDING];
    end

    // Soft reset holds every flag low except bus error and error warning
    if (st_ff.soft_mode) begin
      nxt_st.flags = nxt_st.flags & ~SOFT_CLR_MASK;
    end
    nxt_st.flags[BIT_RESERVED] = 1'b0;
  end

  // ****************************************************
  // Interrupt status and mask
  // ****************************************************
  logic [FLAG_W-1:0] irq_set;

  // A flag going high is the event that reaches the line
  assign irq_set = nxt_st.flags & ~st_ff.flags;

  cif_irq_ctl #(
    .W(FLAG_W)
  ) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(irq_set),
    .clr_we(irq_clr_we),
    .clr_bits(wr_bits),
    .mask_we(irq_mask_we),
    .mask_bits(merge_lanes(irq_mask, st_ff.w_data, st_ff.w_strb)),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq_int)
  );

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.enable <= ENABLE_RST;
      st_ff.soft_mode <= SOFT_MODE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign rx_buf_release = st_ff.release_pulse;
  assign soft_reset_mode = st_ff.soft_mode;
  assign irq = irq_int;

  // Protection bits carry no meaning for these registers
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule

/* File: dv/cif_core_model.sv */
`timescale 1ns/1ns
module cif_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Message arrival and release
  input wire logic push,
  input wire logic rx_buf_release,
  // Buffer level
  output logic rx_buf_status
);
  // ****************************************
  // Receive buffer occupancy
  // ****************************************
  logic [3:0] msgs_ff;
  // Level drops the edge after a release empties it, as a real core would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msgs_ff <= 4'h0;
    end else begin
      msgs_ff <= msgs_ff + 4'(push) - 4'(rx_buf_release && msgs_ff != 4'h0);
    end
  end
  assign rx_buf_status = msgs_ff != 4'h0;
endmodule

/* File: dv/cif_flag_logic_asserts.sv */
`timescale 1ns/1ns
module cif_flag_logic_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [cif_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Core side and interrupt
  input wire logic rx_buf_release,
  input wire logic soft_reset_mode,
  input wire logic irq
);
  import cif_pkg::*;
  // ****************************************
  // Checks
  // ****************************************
  logic rd_flags_ff;
  // Tracks whether the read in flight targets the flag word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_flags_ff <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_flags_ff <= s_axi_araddr[AXI_AW-1:2] == '0;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property ($rose(aresetn) |-> !irq &&
    !s_axi_rvalid && !s_axi_bvalid && !soft_reset_mode && !rx_buf_release)
    else $error("outputs active right after reset");
  a_flag_reserved: assert property (s_axi_rvalid && rd_flags_ff |->
    s_axi_rdata[4] == 1'b0 && s_axi_rdata[31:9] == '0)
    else $error("reserved flag word bits not zero");
  a_release_pulse: assert property (rx_buf_release |=>
    !rx_buf_release) else $error("release pulse too long");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data not held");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while busy");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response not held");
  // A freed beat may be taken while the answer waits; it is held, not run
  a_wr_refuse: assert property ($rose(s_axi_bvalid) |->
    !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write answered without both beats held");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_release: cover property (rx_buf_release);
  c_irq: cover property ($rose(irq));
endmodule
bind cif_flag_logic cif_flag_logic_asserts chk_u (.aclk, .aresetn,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rx_buf_release,
  .soft_reset_mode, .irq);

/* File: dv/cif_flag_logic_bench.sv */
`timescale 1ns/1ns
module cif_flag_logic_bench;
  import cif_pkg::*;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic id_rx_evt = 1'b0, filter_bypass = 1'b1, bus_err_evt = 1'b0;
  logic arb_lost_evt = 1'b0, overrun_evt = 1'b0, push = 1'b0;
  logic err_status = 1'b0, bus_status = 1'b0, tx_buf1_status = 1'b0;
  logic [CNT_W-1:0] tx_err_cnt = 8'h7F, rx_err_cnt = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_buf_release, soft_reset_mode, irq, rx_buf_status;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [8:0] en, mk;
  int errors = 0, n_compared = 0, seed = 32'hA229FED8, k;

  cif_flag_logic dut_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .id_rx_evt, .filter_bypass,
    .bus_err_evt, .arb_lost_evt, .tx_err_cnt, .rx_err_cnt, .overrun_evt,
    .err_status, .bus_status, .tx_buf1_status, .rx_buf_status,
    .rx_buf_release, .soft_reset_mode, .irq);
  cif_core_model core_u (.aclk, .aresetn, .push, .rx_buf_release,
    .rx_buf_status);

  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;

  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  // No cycle count assumed: only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // One event of kind k from the protocol core, then settle
  task automatic fire(input int k);
    @(posedge aclk);
    case (k)
      0: id_rx_evt <= 1'b1;
      1: bus_err_evt <= 1'b1;
      2: arb_lost_evt <= 1'b1;
      3: tx_err_cnt <= tx_err_cnt ^ 8'hFF;
      4: overrun_evt <= 1'b1;
      5: err_status <= !err_status;
      6: tx_buf1_status <= 1'b1;
      default: bus_status <= !bus_status;
    endcase
    @(posedge aclk);
    id_rx_evt <= 1'b0;
    bus_err_evt <= 1'b0;
    arb_lost_evt <= 1'b0;
    overrun_evt <= 1'b0;
    tx_buf1_status <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  function automatic logic [31:0] exp_word(input int k, input logic [8:0] e);
    int b;
    case (k)
      0: b = 8;
      1: b = 7;
      2: b = 6;
      3: b = 5;
      4: b = 3;
      6: b = 1;
      default: b = 2;
    endcase
    exp_word = 32'h0;
    exp_word[b] = e[b];
  endfunction

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge aclk);
    rx_err_cnt <= 8'($random(seed)) & 8'h7F;
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFF_ENABLE);
    chk(rd_d, 32'h0);
    rd(OFF_IRQ_MASK);
    chk(rd_d, 32'h0);
    rd(OFF_INT_CAPT);
    chk(rd_d, 32'h0);
    rd(8'h18);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(OFF_INT_CAPT, 32'h1FF);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(OFF_ENABLE, 32'h1FF);
    rd(OFF_ENABLE);
    chk(rd_d, 32'h1EF);
    rd(OFF_COMMAND);
    chk(rd_d, 32'h0);
    $display("test registers done");
    // Random enables, masks and events; each read must clear the last
    mk = 9'($random(seed));
    wr(OFF_IRQ_MASK, {23'h0, mk});
    for (int i = 0; i < 24; i++) begin
      en = 9'($random(seed));
      k = $random(seed) & 7;
      wr(OFF_ENABLE, {23'h0, en});
      fire(k);
      chk({31'h0, irq}, {31'h0, |(exp_word(k, en) & {23'h0, mk})});
      rd(OFF_INT_CAPT);
      chk(rd_d, exp_word(k, en));
      wr(OFF_IRQ_STATUS, 32'h1FF);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test events done");
    // No flag for an identifier while filtering is active
    wr(OFF_ENABLE, 32'h1FF);
    filter_bypass <= 1'b0;
    fire(0);
    rd(OFF_INT_CAPT);
    chk(rd_d, 32'h0);
    filter_bypass <= 1'b1;
    // Soft mode keeps only bus error and warning flags
    wr(OFF_MODE, 32'h1);
    chk({31'h0, soft_reset_mode}, 32'h1);
    fire(1);
    fire(2);
    rd(OFF_INT_CAPT);
    chk(rd_d, 32'h80);
    wr(OFF_MODE, 32'h0);
    $display("test bypass and soft mode done");
    // Two messages, then release them one by one
    @(posedge aclk);
    push <= 1'b1;
    repeat (2) @(posedge aclk);
    push <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(OFF_INT_CAPT);
    chk(rd_d, 32'h1);
    rd(OFF_INT_CAPT);
    chk(rd_d, 32'h1);
    wr(OFF_COMMAND, 32'h1);
    repeat (4) @(posedge aclk);
    rd(OFF_INT_CAPT);
    chk(rd_d, 32'h1);
    wr(OFF_COMMAND, 32'h1);
    repeat (4) @(posedge aclk);
    rd(OFF_INT_CAPT);
    chk(rd_d, 32'h0);
    $display("test receive done");
    final_report;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    errors++;
    final_report;
  end
endmodule
